// [src/scan_tap_pkg.sv]
/*
 * Constants for the SRAM boundary-scan test port: instruction codes,
 * register lengths, reset values and boundary cell presets.
 * Assumes a single system clock that oversamples the test clock.
 */
package scan_tap_pkg;

   // ----------------------------------------------------------------
   // Register sizes
   // ----------------------------------------------------------------
   localparam int IR_LEN = 3;
   localparam int ID_LEN = 32;
   localparam int BSR_LEN = 89;
   localparam int SYNC_STAGES = 2;

   // ----------------------------------------------------------------
   // Instruction codes
   // ----------------------------------------------------------------
   localparam logic [2:0] INS_EXTEST = 3'h0;
   localparam logic [2:0] INS_IDCODE = 3'h1;
   localparam logic [2:0] INS_SAMPLE_Z = 3'h2;
   localparam logic [2:0] INS_SAMPLE_PRE = 3'h4;
   localparam logic [2:0] INS_BYPASS = 3'h7;
   localparam logic [2:0] IR_RESET = INS_IDCODE;
   localparam logic [1:0] IR_CAPTURE = 2'h1;

   // ----------------------------------------------------------------
   // Boundary register presets
   // ----------------------------------------------------------------
   // Index 88 is cell 89, the internal output-enable cell, preset high.
   localparam int OE_CELL = 88;
   localparam logic [88:0] BSR_PRESET = {1'b1, 88'h0};

   // Identification word: value is arbitrary, bit 0 marks presence.
   localparam logic [31:0] ID_VALUE_DEFAULT = 32'h1234_5679;

   // ----------------------------------------------------------------
   // Controller states
   // ----------------------------------------------------------------
   typedef enum logic [15:0] {
      ST_RESET = 16'h0001, ST_IDLE = 16'h0002, ST_SEL_DR = 16'h0004,
      ST_CAP_DR = 16'h0008, ST_SH_DR = 16'h0010, ST_EX1_DR = 16'h0020,
      ST_PAU_DR = 16'h0040, ST_EX2_DR = 16'h0080, ST_UPD_DR = 16'h0100,
      ST_SEL_IR = 16'h0200, ST_CAP_IR = 16'h0400, ST_SH_IR = 16'h0800,
      ST_EX1_IR = 16'h1000, ST_PAU_IR = 16'h2000, ST_EX2_IR = 16'h4000,
      ST_UPD_IR = 16'h8000
   } tap_state_t;

endpackage : scan_tap_pkg

// [src/pin_sync.sv]
/*
 * Two flip-flop synchroniser for a vector of pins.
 * Assumes inputs are asynchronous to clk_i; only the second stage is read.
 */
module pin_sync #(
   parameter int WIDTH = 1
) (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic [WIDTH-1:0] d_i,
   output logic [WIDTH-1:0] q_o
);
   logic [WIDTH-1:0] meta_q;

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         meta_q <= '0;
         q_o <= '0;
      end else begin
         meta_q <= d_i;
         q_o <= meta_q;
      end
   end
endmodule : pin_sync

// [src/sram_boundary_scan_tap.sv]
/*
 * Boundary-scan test port of a pipelined SRAM: controller, instruction,
 * bypass, identification and 89-cell boundary registers, output float control.
 * Assumes the test clock is far slower than ref_clk_i (at least 4 samples
 * per phase); the ring pins are sampled by ref_clk_i.
 */
// Summary of operation
// - 3-bit instruction; 000 drives boundary cells out
// - 001 routes 32-bit identification register
// - 010 scans boundary and floats data outputs
// - 100 captures ring, boundary path, memory untouched
// - 111 routes single-bit bypass register
// - Unconnected-ball cells hold fixed low
// - 89 cells; internal last cell preset high
// - Identification instruction after reset or test-reset
// - Under 000, latched cell 89 enables drivers
// - 100 Capture-DR snapshots pins; shift concurrently
// - Float stays until new instruction at Update-IR or test-logic-reset
module sram_boundary_scan_tap
   import scan_tap_pkg::*;
#(
   parameter logic [31:0] ID_VALUE = scan_tap_pkg::ID_VALUE_DEFAULT,
   // Ones mark cells whose ball is unconnected.
   parameter logic [88:0] NC_MASK = 89'h0
) (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_b_i,
   // Test port pins
   input wire logic tck_i,
   input wire logic tms_i,
   input wire logic tdi_i,
   output logic tdo_o,
   output logic tdo_oe_o,
   // I/O ring
   input wire logic [scan_tap_pkg::BSR_LEN-1:0] ring_i,
   output logic [scan_tap_pkg::BSR_LEN-1:0] bsr_par_o,
   output logic extest_o,
   output logic data_float_o
);
   import scan_tap_pkg::*;

   // The enable cell has no ball behind it, so it may not be marked unconnected.
   if (BSR_LEN <= OE_CELL || ID_VALUE[0] != 1'b1 || NC_MASK[OE_CELL] != 1'b0) begin : g_bad_param
      $error("bad scan tap parameters");
   end

   // ----------------------------------------------------------------
   // Reset and pin synchronisers
   // ----------------------------------------------------------------
   logic rst_m_q, rst_q;
   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rst_m_q <= 1'b0;
         rst_q <= 1'b0;
      end else begin
         rst_m_q <= 1'b1;
         rst_q <= rst_m_q;
      end
   end

   logic [2:0] pins_s;
   logic [BSR_LEN-1:0] ring_s;
   pin_sync #(.WIDTH(3)) u_pin_sync (
      .clk_i(ref_clk_i),
      .rst_b_i(rst_q),
      .d_i({tck_i, tms_i, tdi_i}),
      .q_o(pins_s)
   );
   pin_sync #(.WIDTH(BSR_LEN)) u_ring_sync (
      .clk_i(ref_clk_i),
      .rst_b_i(rst_q),
      .d_i(ring_i),
      .q_o(ring_s)
   );

   logic tck_q, rise, fall;
   always_ff @(posedge ref_clk_i or negedge rst_q) begin
      if (!rst_q) begin
         tck_q <= 1'b0;
      end else begin
         tck_q <= pins_s[2];
      end
   end
   assign rise = pins_s[2] & ~tck_q;
   assign fall = ~pins_s[2] & tck_q;

   // ----------------------------------------------------------------
   // Controller
   // ----------------------------------------------------------------
   tap_state_t st_q, st_d;
   always_comb begin
      st_d = st_q;
      case (st_q)
         ST_RESET: st_d = pins_s[1] ? ST_RESET : ST_IDLE;
         ST_IDLE: st_d = pins_s[1] ? ST_SEL_DR : ST_IDLE;
         ST_SEL_DR: st_d = pins_s[1] ? ST_SEL_IR : ST_CAP_DR;
         ST_CAP_DR: st_d = pins_s[1] ? ST_EX1_DR : ST_SH_DR;
         ST_SH_DR: st_d = pins_s[1] ? ST_EX1_DR : ST_SH_DR;
         ST_EX1_DR: st_d = pins_s[1] ? ST_UPD_DR : ST_PAU_DR;
         ST_PAU_DR: st_d = pins_s[1] ? ST_EX2_DR : ST_PAU_DR;
         ST_EX2_DR: st_d = pins_s[1] ? ST_UPD_DR : ST_SH_DR;
         ST_UPD_DR: st_d = pins_s[1] ? ST_SEL_DR : ST_IDLE;
         ST_SEL_IR: st_d = pins_s[1] ? ST_RESET : ST_CAP_IR;
         ST_CAP_IR: st_d = pins_s[1] ? ST_EX1_IR : ST_SH_IR;
         ST_SH_IR: st_d = pins_s[1] ? ST_EX1_IR : ST_SH_IR;
         ST_EX1_IR: st_d = pins_s[1] ? ST_UPD_IR : ST_PAU_IR;
         ST_PAU_IR: st_d = pins_s[1] ? ST_EX2_IR : ST_PAU_IR;
         ST_EX2_IR: st_d = pins_s[1] ? ST_UPD_IR : ST_SH_IR;
         ST_UPD_IR: st_d = pins_s[1] ? ST_SEL_DR : ST_IDLE;
         default: st_d = ST_RESET;
      endcase
   end

   always_ff @(posedge ref_clk_i or negedge rst_q) begin
      if (!rst_q) begin
         st_q <= ST_RESET;
      end else if (rise) begin
         st_q <= st_d;
      end
   end

   // ----------------------------------------------------------------
   // Instruction register
   // ----------------------------------------------------------------
   logic [IR_LEN-1:0] ir_sh_q, ir_q;
   always_ff @(posedge ref_clk_i or negedge rst_q) begin
      if (!rst_q) begin
         ir_sh_q <= IR_RESET;
         ir_q <= IR_RESET;
      end else if (rise) begin
         if (st_q == ST_RESET) begin
            ir_q <= IR_RESET;
         end else if (st_q == ST_UPD_IR) begin
            ir_q <= ir_sh_q;
         end
         if (st_q == ST_CAP_IR) begin
            ir_sh_q <= {1'b0, IR_CAPTURE};
         end else if (st_q == ST_SH_IR) begin
            ir_sh_q <= {pins_s[0], ir_sh_q[IR_LEN-1:1]};
         end
      end
   end

   logic sel_bsr, sel_id;
   // Reserved codes fall through to bypass.
   assign sel_bsr = (ir_q == INS_EXTEST) || (ir_q == INS_SAMPLE_Z)
      || (ir_q == INS_SAMPLE_PRE);
   assign sel_id = (ir_q == INS_IDCODE);

   // ----------------------------------------------------------------
   // Data registers
   // ----------------------------------------------------------------
   logic byp_q;
   logic [ID_LEN-1:0] id_q;
   logic [BSR_LEN-1:0] bsr_q, upd_q;
   always_ff @(posedge ref_clk_i or negedge rst_q) begin
      if (!rst_q) begin
         byp_q <= 1'b0;
         id_q <= '0;
         bsr_q <= BSR_PRESET;
      end else if (rise) begin
         if (st_q == ST_CAP_DR) begin
            byp_q <= 1'b0;
            id_q <= ID_VALUE;
            // Cell 89 captures its own latched value; no ball behind it.
            bsr_q <= {upd_q[OE_CELL], ring_s[BSR_LEN-2:0] & ~NC_MASK[BSR_LEN-2:0]};
         end else if (st_q == ST_SH_DR) begin
            byp_q <= pins_s[0];
            id_q <= {pins_s[0], id_q[ID_LEN-1:1]};
            if (sel_bsr) begin
               bsr_q <= {pins_s[0], bsr_q[BSR_LEN-1:1]};
            end
         end
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_q) begin
      if (!rst_q) begin
         upd_q <= BSR_PRESET;
      end else if (rise) begin
         if (st_q == ST_RESET) begin
            upd_q <= BSR_PRESET;
         end else if (st_q == ST_UPD_DR && sel_bsr) begin
            upd_q <= bsr_q & ~NC_MASK;
         end
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   // TDO changes on the falling test clock so the controller samples it safely.
   logic shifting;
   assign shifting = (st_q == ST_SH_DR) || (st_q == ST_SH_IR);
   always_ff @(posedge ref_clk_i or negedge rst_q) begin
      if (!rst_q) begin
         tdo_o <= 1'b0;
         tdo_oe_o <= 1'b0;
      end else if (fall) begin
         tdo_oe_o <= shifting;
         if (st_q == ST_SH_IR) begin
            tdo_o <= ir_sh_q[0];
         end else if (sel_bsr) begin
            tdo_o <= bsr_q[0];
         end else if (sel_id) begin
            tdo_o <= id_q[0];
         end else begin
            tdo_o <= byp_q;
         end
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_q) begin
      if (!rst_q) begin
         bsr_par_o <= BSR_PRESET;
         extest_o <= 1'b0;
         data_float_o <= 1'b0;
      end else begin
         bsr_par_o <= upd_q;
         extest_o <= (ir_q == INS_EXTEST);
         data_float_o <= (ir_q == INS_SAMPLE_Z)
            || ((ir_q == INS_EXTEST) && !upd_q[OE_CELL]);
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   AST_RESET_ID: assert property (@(posedge ref_clk_i) disable iff (!rst_q)
      (rise && st_q == ST_RESET) |=> ir_q == INS_IDCODE) else $error("reset did not select id");
   AST_IR_LOAD: assert property (@(posedge ref_clk_i) disable iff (!rst_q)
      (rise && st_q == ST_UPD_IR) |=> ir_q == $past(ir_sh_q)) else $error("ir not updated");
   AST_IR_HOLD: assert property (@(posedge ref_clk_i) disable iff (!rst_q)
      (!(rise && (st_q == ST_UPD_IR || st_q == ST_RESET))) |=> $stable(ir_q)) else $error("ir changed");
   AST_FLOAT: assert property (@(posedge ref_clk_i) disable iff (!rst_q)
      ir_q == INS_SAMPLE_Z |=> data_float_o) else $error("outputs not floated");
   AST_EXT_OE: assert property (@(posedge ref_clk_i) disable iff (!rst_q)
      ir_q == INS_EXTEST |=> data_float_o == !$past(upd_q[OE_CELL])) else $error("oe cell ignored");
   AST_SAFE: assert property (@(posedge ref_clk_i) disable iff (!rst_q)
      (ir_q != INS_SAMPLE_Z && ir_q != INS_EXTEST) |=> !data_float_o && !extest_o)
      else $error("memory disturbed");
   AST_CAPTURE: assert property (@(posedge ref_clk_i) disable iff (!rst_q)
      (rise && st_q == ST_CAP_DR) |=> bsr_q[BSR_LEN-2:0] == ($past(ring_s[BSR_LEN-2:0]) & ~NC_MASK[BSR_LEN-2:0]))
      else $error("capture wrong");
   AST_NC_LOW: assert property (@(posedge ref_clk_i) disable iff (!rst_q)
      (upd_q & NC_MASK) == '0) else $error("nc cell not low");
   AST_PRESET: assert property (@(posedge ref_clk_i) disable iff (!rst_q)
      (rise && st_q == ST_RESET) |=> upd_q[OE_CELL]) else $error("cell 89 not high");
   AST_BYP: assert property (@(posedge ref_clk_i) disable iff (!rst_q)
      (rise && st_q == ST_SH_DR) |=> byp_q == $past(pins_s[0])) else $error("bypass broken");
   AST_ID: assert property (@(posedge ref_clk_i) disable iff (!rst_q)
      (rise && st_q == ST_CAP_DR) |=> id_q == ID_VALUE) else $error("id not loaded");
   COV_UPD_IR: cover property (@(posedge ref_clk_i) rise && st_q == ST_UPD_IR);
   COV_EXTEST: cover property (@(posedge ref_clk_i) extest_o && data_float_o);
   COV_SAMPZ: cover property (@(posedge ref_clk_i) ir_q == INS_SAMPLE_Z);
   COV_SHIFT: cover property (@(posedge ref_clk_i) rise && st_q == ST_SH_DR && sel_bsr);
endmodule : sram_boundary_scan_tap

// [tb/scan_host_model.sv]
/*
 * Board-side test controller model: makes the test clock, mode select and
 * serial input, and samples the serial output.
 * Assumes a 50 MHz bench clock and calls made at its falling edge; one test
 * clock period is eight bench cycles (160 ns).
 */
module scan_host_model (
   // Bench clock
   input wire logic ref_clk_i,
   // Test port pins
   output logic tck_o,
   output logic tms_o,
   output logic tdi_o,
   input wire logic tdo_i,
   input wire logic tdo_oe_i
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      tck_o = 1'b0;
      tms_o = 1'b1;
      tdi_o = 1'b0;
   end

   // ----------------------------------------------------------------
   // Clocking
   // ----------------------------------------------------------------
   // The serial output is read just before the falling edge, because the
   // port only moves it a few bench cycles after that edge.
   task automatic tick(input logic tms, input logic tdi, output logic tdo);
      tms_o = tms;
      tdi_o = tdi;
      repeat (4) @(negedge ref_clk_i);
      tck_o = 1'b1;
      repeat (4) @(negedge ref_clk_i);
      // A released serial output floats up to the board pull-up.
      tdo = tdo_oe_i ? tdo_i : 1'b1;
      tck_o = 1'b0;
   endtask : tick

   // ----------------------------------------------------------------
   // Scans
   // ----------------------------------------------------------------
   // Five ones reach test-logic-reset from any state; the serial input toggles when unused.
   task automatic reset_tap();
      logic t;
      repeat (5) tick(1'b1, ~tdi_o, t);
      tick(1'b0, ~tdi_o, t);
   endtask : reset_tap

   // Reserved codes go out only when the bench asks for misuse on purpose.
   // Otherwise bypass is loaded in their place.
   task automatic scan_ir(input logic [2:0] code, input bit misuse, output logic [2:0] cap);
      logic t;
      logic [2:0] ld;
      ld = code;
      if (!misuse && (code == 3'h3 || code == 3'h5 || code == 3'h6)) begin
         ld = 3'h7;
      end
      tick(1'b1, ~tdi_o, t);
      tick(1'b1, ~tdi_o, t);
      tick(1'b0, ~tdi_o, t);
      tick(1'b0, ~tdi_o, t);
      for (int i = 0; i < 3; i++) begin
         tick(i == 2, ld[i], cap[i]);
      end
      tick(1'b1, ~tdi_o, t);
      tick(1'b0, ~tdi_o, t);
   endtask : scan_ir

   task automatic scan_dr(input int n, input logic [127:0] din, output logic [127:0] dout);
      logic t;
      dout = '0;
      tick(1'b1, ~tdi_o, t);
      tick(1'b0, ~tdi_o, t);
      tick(1'b0, ~tdi_o, t);
      for (int i = 0; i < n; i++) begin
         tick(i == n - 1, din[i], dout[i]);
      end
      tick(1'b1, ~tdi_o, t);
      tick(1'b0, ~tdi_o, t);
   endtask : scan_dr

endmodule : scan_host_model

// [tb/tb.sv]
/*
 * Self-checking bench for the boundary-scan test port: every instruction
 * code, scan lengths, capture values, preload, float control and resets.
 * Assumes scan_tap_pkg and the controller model scan_host_model.
 */
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin fail_count++; \
   $display("BAD %s exp %h got %h", nm, e, g); end end
module tb
   import scan_tap_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   // Arbitrary unconnected cells, to see that they capture low.
   localparam logic [88:0] NC = 89'h0f0_0000_0000_0000_0f00;
   logic ref_clk, rst_b, tck, tms, tdi, tdo, tdo_oe, extest, dfloat;
   logic [88:0] ring, par, pm;
   int n_checks, fail_count, oe_cycles;

   sram_boundary_scan_tap #(.NC_MASK(NC)) i_dut (.ref_clk_i(ref_clk), .rst_b_i(rst_b), .tck_i(tck),
      .tms_i(tms), .tdi_i(tdi), .tdo_o(tdo), .tdo_oe_o(tdo_oe), .ring_i(ring), .bsr_par_o(par),
      .extest_o(extest), .data_float_o(dfloat));
   scan_host_model i_host (.ref_clk_i(ref_clk), .tck_o(tck), .tms_o(tms), .tdi_o(tdi), .tdo_i(tdo),
      .tdo_oe_i(tdo_oe));

   // Counts bench cycles with the serial output driven; sampled off the launching edge.
   always @(negedge ref_clk) begin
      if (tdo_oe === 1'b1) begin
         oe_cycles++;
      end
   end

   initial begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end

   // ----------------------------------------------------------------
   // Expectations
   // ----------------------------------------------------------------
   function automatic int len_of(input logic [2:0] c);
      if (c == INS_EXTEST || c == INS_SAMPLE_Z || c == INS_SAMPLE_PRE) return BSR_LEN;
      return (c == INS_IDCODE) ? ID_LEN : 1;
   endfunction : len_of

   function automatic logic [127:0] cap_of(input logic [2:0] c);
      if (len_of(c) == BSR_LEN) return 128'({pm[88], ring[87:0] & ~NC[87:0]});
      return (c == INS_IDCODE) ? 128'(ID_VALUE_DEFAULT) : 128'h0;
   endfunction : cap_of

   task automatic check_pins(input logic [2:0] c);
      `CHK("extest", c == INS_EXTEST, extest)
      `CHK("float", c == INS_SAMPLE_Z || (c == INS_EXTEST && !pm[88]), dfloat)
      `CHK("parallel", pm & ~NC, par)
   endtask : check_pins

   // Shifts eight bits beyond the register so the tail shows its length.
   task automatic run_dr(input logic [2:0] c, input int pass);
      logic [127:0] din, dout, dexp, m;
      int len;
      int n0;
      len = len_of(c);
      din = {$urandom, $urandom, $urandom, $urandom};
      if (c == INS_SAMPLE_PRE) din[96] = pass[0];
      m = (128'h1 << (len + 8)) - 128'h1;
      dexp = ((din << len) | cap_of(c)) & m;
      n0 = oe_cycles;
      i_host.scan_dr(len + 8, din, dout);
      `CHK("scan out", dexp, dout & m)
      `CHK("dr enable", 8 * (len + 8), oe_cycles - n0)
      if (len == BSR_LEN) pm = din[96:8];
      check_pins(c);
   endtask : run_dr

   // Resets the port, checks the reset values, then walks to Idle before scanning.
   task automatic power_up();
      rst_b = 1'b0;
      repeat (8) @(negedge ref_clk);
      rst_b = 1'b1;
      repeat (5) @(negedge ref_clk);
      pm = BSR_PRESET;
      `CHK("preset", BSR_PRESET, par)
      check_pins(INS_IDCODE);
      i_host.reset_tap();
      run_dr(INS_IDCODE, 0);
   endtask : power_up

   task automatic results();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : results

   // ----------------------------------------------------------------
   // Sequence
   // ----------------------------------------------------------------
   initial begin
      logic [2:0] irc;
      int n0;
      ring = '0;
      n_checks = 0;
      fail_count = 0;
      void'($urandom(32'h125f));
      power_up();
      $display("test reset done");
      for (int pass = 0; pass < 2; pass++) begin
         for (int c = 0; c < 8; c++) begin
            ring = 89'({$urandom, $urandom, $urandom});
            // Reserved codes really go out only in the second pass, as a misuse corner case.
            n0 = oe_cycles;
            i_host.scan_ir(3'(c), pass == 1, irc);
            `CHK("ir capture", 3'b001, irc)
            `CHK("ir enable", 8 * IR_LEN, oe_cycles - n0)
            check_pins(3'(c));
            run_dr(3'(c), pass);
         end
         $display("test codes pass %0d done", pass);
      end
      i_host.reset_tap();
      pm = BSR_PRESET;
      `CHK("preset", BSR_PRESET, par)
      check_pins(INS_IDCODE);
      run_dr(INS_IDCODE, 0);
      $display("test test-logic-reset done");
      power_up();
      $display("test mid-run reset done");
      results();
   end

   initial begin
      repeat (100000) @(posedge ref_clk);
      fail_count++;
      results();
   end

endmodule : tb
